// file: common/acmrd_lock_if.sv
// Link between the register top and the lock tracker.
// Assumes both ends on the master clock.
`timescale 1ns/1ns
interface acmrd_lock_if;
  logic        ref_edge;
  logic [3:0]  bandwidth;
  logic [14:0] edge_target;
  logic        quick;
  logic        locked;
  logic [15:0] estimate;

  modport ctrl (output ref_edge, output bandwidth, output edge_target, output quick,
                input locked, input estimate);
  modport track (input ref_edge, input bandwidth, input edge_target, input quick,
                 output locked, output estimate);
endinterface

// file: common/acmrd_pkg.sv
// Constants shared by the audio clock master, routing and lock tracking block.
// Assumes a single 100 MHz master clock domain for all logic.
package acmrd_pkg;

  // Register indices; byte address is four times the low six index bits
  localparam logic [7:0] ACMRD_IDX_FORMAT  = 8'h01;
  localparam logic [7:0] ACMRD_IDX_MASTER  = 8'h0a;
  localparam logic [7:0] ACMRD_IDX_ROUTING = 8'h0b;
  localparam logic [7:0] ACMRD_IDX_BW      = 8'h0c;
  localparam logic [7:0] ACMRD_IDX_STATUS  = 8'h40;

  // Reset values
  localparam logic [7:0] ACMRD_RST_MASTER  = 8'h02;
  localparam logic [7:0] ACMRD_RST_ROUTING = 8'h02;
  localparam logic [7:0] ACMRD_RST_BW      = 8'h5a;
  localparam logic [7:0] ACMRD_RST_FORMAT  = 8'h00;

  // Field positions in clock_master_control
  localparam int ACMRD_MC_ENABLE     = 7;
  localparam int ACMRD_MC_RATIO_HI   = 6;
  localparam int ACMRD_MC_RATIO_LO   = 5;
  localparam int ACMRD_MC_QUICK      = 4;
  localparam int ACMRD_MC_EDGES_HI   = 3;
  // Field positions in channel_routing
  localparam int ACMRD_RT_SPDIF_HI   = 6;
  localparam int ACMRD_RT_SPDIF_LO   = 4;
  localparam int ACMRD_RT_SWAP2      = 3;
  localparam int ACMRD_RT_SWAP1      = 2;
  localparam int ACMRD_RT_SRC2       = 1;
  localparam int ACMRD_RT_SRC1       = 0;
  // Field positions in lock_loop_bandwidth
  localparam int ACMRD_BW_PCM_HI     = 7;
  localparam int ACMRD_BW_PCM_LO     = 4;
  localparam int ACMRD_BW_BIT_HI     = 3;
  // Routing top bit is reserved and reads zero
  localparam logic [7:0] ACMRD_ROUTING_MASK = 8'h7f;
  localparam logic [7:0] ACMRD_FORMAT_MASK  = 8'h03;

  // Input formats held in the format_select register
  typedef enum logic [1:0] {
    ACMRD_FMT_I2S   = 2'h0,
    ACMRD_FMT_SPDIF = 2'h1,
    ACMRD_FMT_DSD   = 2'h2
  } acmrd_fmt_t;

  // Bit clock half periods, master clock cycles
  localparam logic [3:0] ACMRD_HALF_DIV4  = 4'h2;
  localparam logic [3:0] ACMRD_HALF_DIV8  = 4'h4;
  localparam logic [3:0] ACMRD_HALF_DIV16 = 4'h8;
  // Frame toggles every 32 bit clock periods
  localparam int         ACMRD_FRAME_RATIO = 64;
  localparam logic [4:0] ACMRD_FRAME_HALF  = 5'(ACMRD_FRAME_RATIO / 2 - 1);

  // Quick lock shortens the edge wait by this shift
  localparam int ACMRD_QUICK_SHIFT = 4;
  // Saturated period counter: reference lost
  localparam logic [15:0] ACMRD_PERIOD_MAX = 16'hffff;

  // AXI responses
  localparam logic [1:0] ACMRD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ACMRD_RESP_SLVERR = 2'h2;

  // Lock edge count per code: longest wait over code plus one
  localparam logic [14:0] ACMRD_EDGES_MAX = 15'h4000;
  function automatic logic [14:0] acmrd_edge_target(input logic [3:0] code);
    return ACMRD_EDGES_MAX / ({11'h0, code} + 15'h1);
  endfunction

  // Lock tracker states, Gray coded along off, acquire, locked
  typedef enum logic [1:0] {
    ACMRD_LK_OFF    = 2'b00,
    ACMRD_LK_ACQ    = 2'b01,
    ACMRD_LK_LOCKED = 2'b11
  } acmrd_lock_state_t;

endpackage

// file: hdl/acmrd_clkgen.sv
// Master mode bit and frame clock generator.
// Assumes clk_i is the master clock and the enable comes from a register.
`timescale 1ns/1ns
module acmrd_clkgen
  import acmrd_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       enable_i,
  input  wire logic [1:0] ratio_i,
  output logic            bit_clk_o,
  output logic            frame_clk_o
);

  logic [3:0] div_cnt_q, div_cnt_d, half;
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic       bit_clk_q, bit_clk_d;
  logic       frame_q, frame_d;

  ////////////////////////////////////////////////////////////////////////////////
  // ratio decode
  always_comb begin
    case (ratio_i)
      2'h0:    half = ACMRD_HALF_DIV4;
      2'h1:    half = ACMRD_HALF_DIV8;
      default: half = ACMRD_HALF_DIV16;
    endcase
  end

  always_comb begin
    div_cnt_d = div_cnt_q;
    bit_cnt_d = bit_cnt_q;
    bit_clk_d = bit_clk_q;
    frame_d   = frame_q;
    if (!enable_i) begin
      // Idle low so a later enable starts from a clean frame
      div_cnt_d = 4'h0;
      bit_cnt_d = 5'h0;
      bit_clk_d = 1'b0;
      frame_d   = 1'b0;
    end else if (div_cnt_q >= half - 4'h1) begin
      div_cnt_d = 4'h0;
      bit_clk_d = ~bit_clk_q;
      // frame moves on bit clock fall
      if (bit_clk_q) begin
        // frame is bit clock over 64
        if (bit_cnt_q == ACMRD_FRAME_HALF) begin
          bit_cnt_d = 5'h0;
          frame_d   = ~frame_q;
        end else begin
          bit_cnt_d = bit_cnt_q + 5'h1;
        end
      end
    end else begin
      div_cnt_d = div_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt_q <= 4'h0;
      bit_cnt_q <= 5'h0;
      bit_clk_q <= 1'b0;
      frame_q   <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      bit_cnt_q <= bit_cnt_d;
      bit_clk_q <= bit_clk_d;
      frame_q   <= frame_d;
    end
  end

  assign bit_clk_o   = bit_clk_q;
  assign frame_clk_o = frame_q;

endmodule

// file: hdl/acmrd_lock.sv
// Lock loop tracker: counts reference edges, follows their period.
// Assumes ref_edge is a one-cycle pulse already synchronised to clk_i.
`timescale 1ns/1ns
module acmrd_lock
  import acmrd_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   reset_n_i,
  acmrd_lock_if.track lk
);

  acmrd_lock_state_t state_q, state_d;
  logic [14:0]       edges_q, edges_d, target;
  logic [15:0]       period_q, period_d;
  logic [15:0]       est_q, est_d;
  logic signed [16:0] err;
  logic [3:0]        shift;

  // edge wait, shortened by quick lock
  assign target = lk.quick ? (lk.edge_target >> ACMRD_QUICK_SHIFT) : lk.edge_target;
  assign err    = $signed({1'b0, period_q}) - $signed({1'b0, est_q});
  assign shift  = 4'hf - lk.bandwidth;

  always_comb begin
    state_d  = state_q;
    edges_d  = edges_q;
    est_d    = est_q;
    period_d = (period_q == ACMRD_PERIOD_MAX) ? period_q : period_q + 16'h1;
    if (lk.ref_edge) begin
      period_d = 16'h1;
      if (lk.bandwidth != 4'h0) begin
        est_d = est_q + 16'(err >>> shift);
      end
      if (edges_q != 15'h7fff) begin
        edges_d = edges_q + 15'h1;
      end
    end
    case (state_q)
      ACMRD_LK_OFF: begin
        edges_d = 15'h0;
        // code zero keeps the loop off
        if (lk.bandwidth != 4'h0) begin
          state_d = ACMRD_LK_ACQ;
        end
      end
      ACMRD_LK_ACQ: begin
        if (lk.bandwidth == 4'h0 || period_q == ACMRD_PERIOD_MAX) begin
          state_d = ACMRD_LK_OFF;
        end else if (edges_q >= target) begin
          state_d = ACMRD_LK_LOCKED;
        end
      end
      ACMRD_LK_LOCKED: begin
        // Lost reference or loop switched off drops the lock
        if (lk.bandwidth == 4'h0 || period_q == ACMRD_PERIOD_MAX) begin
          state_d = ACMRD_LK_OFF;
        end
      end
      default: state_d = ACMRD_LK_OFF;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q  <= ACMRD_LK_OFF;
      edges_q  <= 15'h0;
      period_q <= 16'h0;
      est_q    <= 16'h0;
    end else begin
      state_q  <= state_d;
      edges_q  <= edges_d;
      period_q <= period_d;
      est_q    <= est_d;
    end
  end

  assign lk.locked   = (state_q == ACMRD_LK_LOCKED);
  assign lk.estimate = est_q;

endmodule

// file: hdl/acmrd_top.sv
// Audio clock master, channel routing and lock loop control with AXI4-Lite registers.
// Assumes clk_i is the master clock; serial pins are synchronised here.
//
// Summary of operation
// - Master enable 0 leaves bit and frame clock pins undriven; 1 drives both.
// - Bit clock is master clock over 4, 8, or 16 by ratio field.
// - Frame clock is bit clock over 64 in master mode.
// - Master mode drives bit clock on clock pin, frame clock on first data pin.
// - Quick-lock bit shortens locking for synchronous 128x master clock sources.
// - Lock waits for the coded number of reference edges, 16384 down to 1024.
// - S/PDIF data taken from pin chosen by three-bit field; codes 5-7 reserved.
// - Per-channel swap bit exchanges that channel's two converter outputs.
// - Per-channel source bit picks left or right input; defaults left, right.
// - Upper bandwidth field sets PCM/S-PDIF loop bandwidth; zero turns loop off.
// - Lower bandwidth field sets bitstream-mode loop bandwidth, reset 1010.
// - PCM and S/PDIF modes track the incoming frame clock, or the generated one in master mode.
// - Bitstream mode tracks the incoming bit clock instead.
// - Higher bandwidth makes the estimate follow the reference faster.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
module acmrd_top
  import acmrd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial pins
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe_n_o,
  input  wire logic        first_data_pin_i,
  output logic             first_data_pin_o,
  output logic             first_data_pin_oe_n_o,
  input  wire logic        second_data_pin_i,
  input  wire logic        general_pin_one_i,
  input  wire logic        general_pin_two_i,
  output logic             spdif_data_o,
  // Sample path, same clock
  input  wire logic [31:0] left_sample_i,
  input  wire logic [31:0] right_sample_i,
  output logic [31:0]      first_dac_a_o,
  output logic [31:0]      first_dac_b_o,
  output logic [31:0]      second_dac_a_o,
  output logic [31:0]      second_dac_b_o,
  output logic             locked_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and AXI state
  logic [7:0]  master_q, master_d, routing_q, routing_d, bw_q, bw_d, format_q, format_d;
  logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic        wstrb0_q, wstrb0_d;
  logic        awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [5:0]  wr_idx, rd_idx;
  logic [7:0]  wr_byte;
  logic        wr_ok;

  // Pin synchronisers and outputs
  logic [4:0]  pin_meta_q, pin_sync_q, pins_raw;
  logic        fclk_prev_q, bclk_prev_q, ref_edge_q, ref_edge_d;
  logic        spdif_q, spdif_d, locked_q;
  logic        gen_bclk, gen_fclk;
  logic        sclk_q, sclk_oe_n_q, fdat_q, fdat_oe_n_q;
  logic [31:0] src1, src2;
  logic [31:0] f_a_q, f_b_q, s_a_q, s_b_q, f_a_d, f_b_d, s_a_d, s_b_d;

  acmrd_lock_if lk ();

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; index is byte address over four
  assign wr_idx  = awaddr_q[7:2];
  assign rd_idx  = s_axi_araddr[7:2];
  assign wr_byte = wdata_q[7:0];
  assign wr_ok   = (wr_idx == ACMRD_IDX_MASTER[5:0]) || (wr_idx == ACMRD_IDX_ROUTING[5:0])
                || (wr_idx == ACMRD_IDX_BW[5:0]) || (wr_idx == ACMRD_IDX_FORMAT[5:0]);

  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb0_d  = wstrb0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    master_d  = master_q;
    routing_d = routing_q;
    bw_d      = bw_q;
    format_d  = format_q;
    if (s_axi_awvalid && awready_q) begin
      aw_full_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_full_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_full_q && w_full_q && !bvalid_q) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_ok ? ACMRD_RESP_OKAY : ACMRD_RESP_SLVERR;
      if (wstrb0_q) begin
        case (wr_idx)
          ACMRD_IDX_MASTER[5:0]:  master_d  = wr_byte;
          // reserved top bit kept at zero
          ACMRD_IDX_ROUTING[5:0]: routing_d = wr_byte & ACMRD_ROUTING_MASK;
          ACMRD_IDX_BW[5:0]:      bw_d      = wr_byte;
          ACMRD_IDX_FORMAT[5:0]:  format_d  = wr_byte & ACMRD_FORMAT_MASK;
          default:                master_d  = master_q;
        endcase
      end
    end
    awready_d = !aw_full_d;
    wready_d  = !w_full_d;
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = ACMRD_RESP_OKAY;
      case (rd_idx)
        ACMRD_IDX_MASTER[5:0]:  rdata_d = {24'h0, master_q};
        ACMRD_IDX_ROUTING[5:0]: rdata_d = {24'h0, routing_q};
        ACMRD_IDX_BW[5:0]:      rdata_d = {24'h0, bw_q};
        ACMRD_IDX_FORMAT[5:0]:  rdata_d = {24'h0, format_q};
        ACMRD_IDX_STATUS[5:0]:  rdata_d = {15'h0, lk.locked, lk.estimate};
        default: begin
          rdata_d = 32'h0;
          rresp_d = ACMRD_RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= 8'h0;
      wdata_q   <= 32'h0;
      wstrb0_q  <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      arready_q <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rresp_q   <= 2'h0;
      rdata_q   <= 32'h0;
      master_q  <= ACMRD_RST_MASTER;
      routing_q <= ACMRD_RST_ROUTING;
      bw_q      <= ACMRD_RST_BW;
      format_q  <= ACMRD_RST_FORMAT;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb0_q  <= wstrb0_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      arready_q <= arready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      master_q  <= master_d;
      routing_q <= routing_d;
      bw_q      <= bw_d;
      format_q  <= format_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock generation and lock tracking
  acmrd_clkgen u_clkgen (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .enable_i    (master_q[ACMRD_MC_ENABLE]),
    .ratio_i     (master_q[ACMRD_MC_RATIO_HI:ACMRD_MC_RATIO_LO]),
    .bit_clk_o   (gen_bclk),
    .frame_clk_o (gen_fclk)
  );

  acmrd_lock u_lock (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .lk        (lk)
  );

  assign lk.bandwidth   = (format_q[1:0] == ACMRD_FMT_DSD) ? bw_q[ACMRD_BW_BIT_HI:0]
                        : bw_q[ACMRD_BW_PCM_HI:ACMRD_BW_PCM_LO];
  assign lk.edge_target = acmrd_edge_target(master_q[ACMRD_MC_EDGES_HI:0]);
  assign lk.quick       = master_q[ACMRD_MC_QUICK];
  assign lk.ref_edge    = ref_edge_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin sampling; only the second stage is read by logic
  assign pins_raw = {general_pin_two_i, general_pin_one_i, first_data_pin_i,
                     second_data_pin_i, serial_clock_pin_i};

  always_comb begin
    ref_edge_d = 1'b0;
    // bitstream mode follows the bit clock
    if (format_q[1:0] == ACMRD_FMT_DSD) begin
      ref_edge_d = pin_sync_q[0] && !bclk_prev_q;
    // PCM modes follow the frame clock, own one in master mode
    end else if (master_q[ACMRD_MC_ENABLE]) begin
      ref_edge_d = gen_fclk && !fclk_prev_q;
    end else begin
      ref_edge_d = pin_sync_q[2] && !fclk_prev_q;
    end
    // S/PDIF source pin, reserved codes give zero
    case (routing_q[ACMRD_RT_SPDIF_HI:ACMRD_RT_SPDIF_LO])
      3'h0:    spdif_d = pin_sync_q[0];
      3'h1:    spdif_d = pin_sync_q[1];
      3'h2:    spdif_d = pin_sync_q[2];
      3'h3:    spdif_d = pin_sync_q[3];
      3'h4:    spdif_d = pin_sync_q[4];
      default: spdif_d = 1'b0;
    endcase
  end

  assign src1 = routing_q[ACMRD_RT_SRC1] ? right_sample_i : left_sample_i;
  assign src2 = routing_q[ACMRD_RT_SRC2] ? right_sample_i : left_sample_i;

  always_comb begin
    f_a_d = routing_q[ACMRD_RT_SWAP1] ? ~src1 : src1;
    f_b_d = routing_q[ACMRD_RT_SWAP1] ? src1 : ~src1;
    s_a_d = routing_q[ACMRD_RT_SWAP2] ? ~src2 : src2;
    s_b_d = routing_q[ACMRD_RT_SWAP2] ? src2 : ~src2;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_meta_q  <= 5'h0;
      pin_sync_q  <= 5'h0;
      fclk_prev_q <= 1'b0;
      bclk_prev_q <= 1'b0;
      ref_edge_q  <= 1'b0;
      spdif_q     <= 1'b0;
      locked_q    <= 1'b0;
      sclk_q      <= 1'b0;
      fdat_q      <= 1'b0;
      sclk_oe_n_q <= 1'b1;
      fdat_oe_n_q <= 1'b1;
      f_a_q       <= 32'h0;
      f_b_q       <= 32'h0;
      s_a_q       <= 32'h0;
      s_b_q       <= 32'h0;
    end else begin
      pin_meta_q  <= pins_raw;
      pin_sync_q  <= pin_meta_q;
      fclk_prev_q <= master_q[ACMRD_MC_ENABLE] ? gen_fclk : pin_sync_q[2];
      bclk_prev_q <= pin_sync_q[0];
      ref_edge_q  <= ref_edge_d;
      spdif_q     <= spdif_d;
      locked_q    <= lk.locked;
      // drive pins only in master mode
      // bit clock on clock pin, frame on first data pin
      sclk_q      <= gen_bclk;
      fdat_q      <= gen_fclk;
      sclk_oe_n_q <= ~master_q[ACMRD_MC_ENABLE];
      fdat_oe_n_q <= ~master_q[ACMRD_MC_ENABLE];
      f_a_q       <= f_a_d;
      f_b_q       <= f_b_d;
      s_a_q       <= s_a_d;
      s_b_q       <= s_b_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign serial_clock_pin_o = sclk_q;
  assign serial_clock_pin_oe_n_o = sclk_oe_n_q;
  assign first_data_pin_o = fdat_q;
  assign first_data_pin_oe_n_o = fdat_oe_n_q;
  assign spdif_data_o = spdif_q;
  assign first_dac_a_o = f_a_q;
  assign first_dac_b_o = f_b_q;
  assign second_dac_a_o = s_a_q;
  assign second_dac_b_o = s_b_q;
  assign locked_o = locked_q;

endmodule

// file: tb/acmrd_checker.sv
// Port assertions of acmrd_top.
// Assumes binding to acmrd_top; reset is asynchronous, active low.
`timescale 1ns/1ns
module acmrd_checker (
  input wire logic        clk_i, reset_n_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic        s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid, s_axi_rready, serial_clock_pin_o,
  input wire logic        serial_clock_pin_oe_n_o, first_data_pin_o, first_data_pin_oe_n_o,
  input wire logic [31:0] s_axi_rdata, first_dac_a_o, first_dac_b_o, second_dac_a_o,
  input wire logic [31:0] second_dac_b_o
);
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read data dropped");
  a_oe_pair: assert property (serial_clock_pin_oe_n_o == first_data_pin_oe_n_o)
    else $error("clock pins not driven together");
  a_dac_pair: assert property ($past(reset_n_i) |-> first_dac_b_o == ~first_dac_a_o &&
    second_dac_b_o == ~second_dac_a_o) else $error("pair not complementary");
  a_frame_fall: assert property ($changed(first_data_pin_o) && !first_data_pin_oe_n_o &&
    !$past(first_data_pin_oe_n_o) |-> $fell(serial_clock_pin_o)) else $error("frame off fall");
  a_bit_min: assert property ($changed(serial_clock_pin_o) && !serial_clock_pin_oe_n_o |=>
    $stable(serial_clock_pin_o) || serial_clock_pin_oe_n_o) else $error("bit half short");
  a_bit_max: assert property ($changed(serial_clock_pin_o) && !serial_clock_pin_oe_n_o |->
    ##[1:8] ($changed(serial_clock_pin_o) || serial_clock_pin_oe_n_o)) else $error("bit half long");
  c_write: cover property (s_axi_bvalid);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_frame: cover property ($changed(first_data_pin_o) && !first_data_pin_oe_n_o);
endmodule
bind acmrd_top acmrd_checker u_acmrd_checker (.*);

// file: tb/acmrd_src_model.sv
// Upstream serial source: bit clock and a frame clock at one sixty-fourth of it.
// Assumes run_i stays low outside streams; both clocks then hold their last levels, low before the first stream.
`timescale 1ns/1ns
module acmrd_src_model (
  input  wire logic run_i,
  output logic      bit_o,
  output logic      frame_o
);
  int n = 0;
  initial begin
    {bit_o, frame_o} = 2'b00;
    forever begin
      #2;
      // Frame moves only after a bit clock fall, as an I2S source does
      if (run_i) begin
        bit_o = ~bit_o;
        n = bit_o ? n : n + 1;
      end
      if (n == 32) begin
        n = 0;
        frame_o = ~frame_o;
      end
    end
  end
endmodule

// file: tb/acmrd_top_tb_top.sv
// Self-checking bench for acmrd_top.
// Assumes the source model and checker are compiled before this file.
`timescale 1ns/1ns
module acmrd_top_tb_top;
  logic clk_i, reset_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, left_sample_i, right_sample_i, first_dac_a_o;
  logic [31:0] first_dac_b_o, second_dac_a_o, second_dac_b_o;
  logic serial_clock_pin_i, serial_clock_pin_o, serial_clock_pin_oe_n_o, first_data_pin_i;
  logic first_data_pin_o, first_data_pin_oe_n_o, second_data_pin_i, general_pin_one_i;
  logic general_pin_two_i, spdif_data_o, locked_o, run, src_bit, src_frame;
  int error_cnt = 0;
  int tests_run = 0;
  // Shared pins: whoever has its enable low owns the wire
  assign serial_clock_pin_i = serial_clock_pin_oe_n_o ? src_bit : serial_clock_pin_o;
  assign first_data_pin_i = first_data_pin_oe_n_o ? src_frame : first_data_pin_o;
  acmrd_top u_acmrd_top (.*);
  acmrd_src_model u_acmrd_src_model (.run_i(run), .bit_o(src_bit), .frame_o(src_frame));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tmo();
    error_cnt++;
    test_done();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50 && s_axi_bvalid !== 1'b1; k++) begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k == 50) tmo();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50 && s_axi_rvalid !== 1'b1; k++) begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k == 50) tmo();
  endtask
  // Edges between two level changes of the chosen generated clock
  task automatic gap(input bit f, output int n);
    logic v;
    for (int j = 0; j < 2; j++) begin
      v = f ? first_data_pin_o : serial_clock_pin_o;
      for (n = 0; n < 3000 && v === (f ? first_data_pin_o : serial_clock_pin_o); n++)
        @(posedge clk_i);
      if (n == 3000) tmo();
    end
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    chk({serial_clock_pin_oe_n_o, first_data_pin_oe_n_o}, 2'h3);
    rd(8'h28, d, r);
    chk(d, 32'h02);
    rd(8'h2c, d, r);
    chk(d, 32'h02);
    rd(8'h30, d, r);
    chk(d, 32'h5a);
    wr(8'h3c, 32'h11, r);
    chk(r, 2'h2);
    rd(8'h3c, d, r);
    chk(r, 2'h2);
    $display("regs done");
  endtask
  task automatic t_route();
    logic [31:0] s1, s2;
    logic [1:0] r;
    for (int i = 0; i < 16; i++) begin
      wr(8'h2c, 32'(i), r);
      left_sample_i <= 32'h0f0f_0000 | 32'(i);
      right_sample_i <= 32'hc3c3_0000 | 32'(i);
      repeat (2) @(posedge clk_i);
      s1 = i[0] ? right_sample_i : left_sample_i;
      s2 = i[1] ? right_sample_i : left_sample_i;
      chk({first_dac_a_o, first_dac_b_o}, i[2] ? {~s1, s1} : {s1, ~s1});
      chk({second_dac_a_o, second_dac_b_o}, i[3] ? {~s2, s2} : {s2, ~s2});
    end
    $display("route done");
  endtask
  task automatic t_spdif();
    logic [4:0] v;
    logic [1:0] r;
    for (int c = 0; c < 5; c++) begin
      wr(8'h2c, 32'h02 | 32'(c) << 4, r);
      for (int p = 2; p < 6; p += 3) begin
        {general_pin_two_i, general_pin_one_i, second_data_pin_i} <= 3'(p);
        repeat (5) @(posedge clk_i);
        v = {p[2], p[1], 1'b0, p[0], 1'b0};
        chk(spdif_data_o, v[c]);
      end
    end
    $display("spdif done");
  endtask
  task automatic t_master();
    int n;
    logic [1:0] r;
    for (int q = 0; q < 4; q++) begin
      // input format stays I2S from reset
      wr(8'h28, 32'h82 | 32'(q) << 5, r);
      gap(0, n);
      chk(n, q > 2 ? 8 : 2 << q);
      gap(1, n);
      chk(n, q > 2 ? 512 : 128 << q);
      chk({serial_clock_pin_oe_n_o, first_data_pin_oe_n_o}, 2'h0);
    end
    wr(8'h28, 32'h02, r);
    repeat (3) @(posedge clk_i);
    chk({serial_clock_pin_oe_n_o, first_data_pin_oe_n_o}, 2'h3);
    $display("master done");
  endtask
  task automatic t_lock();
    int k;
    logic [1:0] r;
    run <= 1'b1;
    wr(8'h28, 32'h00, r);
    repeat (3000) @(posedge clk_i);
    chk(locked_o, 1'b0);
    // quick lock set, but PCM bandwidth field zero keeps the loop off
    wr(8'h30, 32'h0a, r);
    wr(8'h28, 32'h10, r);
    repeat (3000) @(posedge clk_i);
    chk(locked_o, 1'b0);
    wr(8'h30, 32'h5a, r);
    for (k = 0; k < 30000 && locked_o !== 1'b1; k++) @(posedge clk_i);
    chk(locked_o, 1'b1);
    $display("lock done");
  endtask
  initial begin
    {reset_n_i, run, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, left_sample_i} = '0;
    {right_sample_i, second_data_pin_i, general_pin_one_i, general_pin_two_i} = '0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_route();
    t_spdif();
    t_master();
    t_lock();
    test_done();
  end
endmodule
